//--- scbm_pkg.sv
// Constants, types and helper functions shared by the two-wire control and
// error-rate measurement logic. Assumes a 50 MHz system clock.
package scbm_pkg;

  // Slave address: top bit fixed high, bit 5 from a pin, bits 4:0 zero.
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h40;
  localparam int SLAVE_ADDR_PIN_BIT = 5;

  // Register subaddresses, eight in a contiguous block.
  localparam logic [7:0] SUB_CTRL = 8'h1A;
  localparam logic [7:0] SUB_POWER = 8'h1B;
  localparam logic [7:0] SUB_STATUS = 8'h1C;
  localparam logic [7:0] SUB_PHASE = 8'h1D;
  localparam logic [7:0] SUB_LENGTH = 8'h1E;
  localparam logic [7:0] SUB_ESTIMATE = 8'h1F;
  localparam logic [7:0] SUB_PHASE_USED = 8'h20;
  localparam logic [7:0] SUB_RESULT = 8'h21;
  localparam logic [7:0] SUB_FIRST = SUB_CTRL;
  localparam logic [7:0] SUB_LAST = SUB_RESULT;

  // Field positions.
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_START_BIT = 3;
  localparam int PWR_ON_BIT = 5;
  localparam int PWR_STBY_BIT = 4;
  localparam int STS_DONE_BIT = 0;
  localparam int STS_BUSY_BIT = 1;
  localparam int STS_AUTO_BIT = 2;

  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PWR_RST = 8'h00;
  localparam logic [5:0] PHASE_RST = 6'h00;
  localparam logic [2:0] LEN_RST = 3'h0;

  // Sample phase: half a unit interval is 180 degrees, in 6 degree steps.
  localparam int PHASE_STEP_DEG = 6;
  localparam int HALF_UI_DEG = 180;
  localparam int PHASE_MAX_STEPS = HALF_UI_DEG / PHASE_STEP_DEG;
  localparam int AUTO_OFFSET_DEG = 36;
  localparam logic [5:0] AUTO_PHASE_STEPS = 6'(AUTO_OFFSET_DEG / PHASE_STEP_DEG);

  // Measurement length is 2^(18 + 3 * code) bits.
  localparam int TALLY_W = 40;
  localparam int LEN_LOG2_MIN = 18;
  localparam int LEN_LOG2_STEP = 3;
  localparam logic [2:0] AUTO_LEN_CODE = 3'h0;
  localparam logic [2:0] TALLY_BYTES = 3'h5;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_SUB = 9'h008,
    ST_SUB_ACK = 9'h010,
    ST_WR = 9'h020,
    ST_WR_ACK = 9'h040,
    ST_RD = 9'h080,
    ST_RD_ACK = 9'h100
  } scbm_state_t;

  typedef struct packed {
    logic run_enable;
    logic [2:0] len_code;
  } scbm_meas_cfg_t;

  // Coarse estimate: one plus the index of the highest set bit of the tally.
  function automatic logic [5:0] scbm_coarse_code(input logic [TALLY_W-1:0] t);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < TALLY_W; i++) begin
      if (t[i]) begin
        c = 6'(i + 1);
      end
    end
    return c;
  endfunction

endpackage

//--- scbm_engine.sv
// Measurement engine on the recovered clock: counts bits and sample errors.
// Assumes start_tgl and cfg come from the system clock domain and that cfg
// stays stable while a run is in progress.
`timescale 1ns/1ns
module scbm_engine #(
  parameter int LEN_LOG2_BASE = scbm_pkg::LEN_LOG2_MIN
) (
  input wire logic rec_clk,
  input wire logic rec_rst_n,
  input wire logic start_tgl,
  input wire scbm_pkg::scbm_meas_cfg_t cfg,
  input wire logic bit_error,
  output logic done_tgl,
  output logic [scbm_pkg::TALLY_W-1:0] tally
);
  import scbm_pkg::*;

  logic start_s1;
  logic start_s2;
  logic start_s3;
  logic en_s1;
  logic en_s2;
  logic running;
  logic [2:0] len_code;
  logic [TALLY_W-1:0] bit_cnt;
  logic [TALLY_W-1:0] err_cnt;
  logic [TALLY_W-1:0] last_bit;

  assign last_bit = (TALLY_W'(1) << (LEN_LOG2_BASE + LEN_LOG2_STEP * int'(len_code)))
                    - TALLY_W'(1);

  always_ff @(posedge rec_clk) begin
    if (!rec_rst_n) begin
      start_s1 <= 1'b0;
      start_s2 <= 1'b0;
      start_s3 <= 1'b0;
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
    end else begin
      start_s1 <= start_tgl;
      start_s2 <= start_s1;
      start_s3 <= start_s2;
      en_s1 <= cfg.run_enable;
      en_s2 <= en_s1;
    end
  end

  // Counting only advances while the circuitry is powered and not in standby.
  always_ff @(posedge rec_clk) begin
    if (!rec_rst_n) begin
      running <= 1'b0;
      len_code <= LEN_RST;
      bit_cnt <= '0;
      err_cnt <= '0;
      done_tgl <= 1'b0;
      tally <= '0;
    end else if (start_s2 != start_s3) begin
      running <= 1'b1;
      len_code <= cfg.len_code;
      bit_cnt <= '0;
      err_cnt <= '0;
    end else if (running && en_s2) begin
      bit_cnt <= bit_cnt + TALLY_W'(1);
      err_cnt <= err_cnt + TALLY_W'(bit_error);
      if (bit_cnt == last_bit) begin
        running <= 1'b0;
        tally <= err_cnt + TALLY_W'(bit_error);
        done_tgl <= ~done_tgl;
      end
    end
  end

endmodule

//--- scbm_top.sv
// Two-wire serial slave with subaddress pointer and error-rate control.
// Assumes the serial pins are asynchronous to clk and the wire is resolved
// outside from sda_oe; bit_error is synchronous to rec_clk.
// Operation
// - Slave address is 1, address pin, then five zeros.
// - Lowest bit of first byte: 1 reads, 0 writes.
// - Start is data falling with clock high; eight bits follow, MSB first.
// - Matching address is acknowledged on pulse nine; otherwise go idle.
// - Second byte is the starting subaddress among eight registers.
// - Subaddress advances after each data byte; single access also works.
// - Start or stop at any point returns the interface to idle or address.
// - Invalid subaddress gets no acknowledge and the interface goes idle.
// - Reading past the last subaddress keeps returning the last register.
// - Power bit low powers measurement down; high powers it up. The code keeps meas_power_on high in autonomous mode whatever the power bit.
// - Power bits both set select reduced-power standby outside autonomous mode.
// - Off to on costs lock; standby to on keeps recovery running.
// - Host supplies phase offset and one of eight measurement lengths.
// - Writing start bit one then zero begins a measurement.
// - At the end the tally is updated and the done flag set.
// - Control bits select a tally byte read from the result register.
// - Host-driven and autonomous modes never run together.
// - Autonomous mode measures repeatedly at fixed offset and decodes an estimate.
// - Select pin low enables autonomous mode; estimate readable as six bits.
// - Phase register offsets sampling by six degree steps within half interval.
`timescale 1ns/1ns
module scbm_top #(
  parameter int LEN_LOG2_BASE = scbm_pkg::LEN_LOG2_MIN
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rec_clk,
  input wire logic rec_rst_n,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_bit5_pin,
  input wire logic coarse_output_select_pin,
  input wire logic bit_error,
  output logic meas_power_on,
  output logic meas_standby,
  output logic relock_request,
  output logic [5:0] phase_offset_steps,
  output logic [5:0] coarse_estimate_output_pin
);
  import scbm_pkg::*;

  // Synchronisers for every pin input except bit_error, which is on rec_clk.
  logic scl_s1;
  logic scl_s2;
  logic scl_d;
  logic sda_s1;
  logic sda_s2;
  logic sda_d;
  logic adr5_s1;
  logic adr5_s2;
  logic sel_s1;
  logic sel_s2;
  logic done_s1;
  logic done_s2;
  logic done_s3;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic auto_mode;
  scbm_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic [7:0] sub_ptr;
  logic rw_read;
  logic wr_strobe;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_byte;
  logic [6:0] my_addr;
  logic [7:0] ctrl_reg;
  logic [7:0] pwr_reg;
  logic [5:0] phase_reg;
  logic [2:0] len_reg;
  logic host_start;
  logic busy;
  logic done_flag;
  logic start_tgl;
  scbm_meas_cfg_t cfg;
  logic [TALLY_W-1:0] error_tally;
  logic [TALLY_W-1:0] engine_tally;
  logic engine_done_tgl;
  logic done_edge;
  logic launch;

  function automatic logic sub_valid(input logic [7:0] s);
    return (s >= SUB_FIRST) && (s <= SUB_LAST);
  endfunction

  function automatic logic [7:0] next_sub(input logic [7:0] s);
    return (s == SUB_LAST) ? s : s + 8'h01;
  endfunction

  // Clamp a signed step count to plus or minus half a unit interval.
  function automatic logic [5:0] clamp_phase(input logic [5:0] v);
    logic signed [6:0] sv;
    sv = 7'(signed'(v));
    if (sv > 7'(PHASE_MAX_STEPS)) begin
      return 6'(PHASE_MAX_STEPS);
    end else if (sv < -7'(PHASE_MAX_STEPS)) begin
      return 6'(-PHASE_MAX_STEPS);
    end
    return v;
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      adr5_s1 <= 1'b0;
      adr5_s2 <= 1'b0;
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
    end else begin
      scl_s1 <= scl_pin;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      adr5_s1 <= address_bit5_pin;
      adr5_s2 <= adr5_s1;
      sel_s1 <= coarse_output_select_pin;
      sel_s2 <= sel_s1;
      done_s1 <= engine_done_tgl;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
    end
  end

  assign scl_rise = scl_s2 && !scl_d;
  assign scl_fall = !scl_s2 && scl_d;
  assign start_seen = scl_s2 && scl_d && sda_d && !sda_s2;
  assign stop_seen = scl_s2 && scl_d && !sda_d && sda_s2;
  assign auto_mode = !sel_s2;
  assign done_edge = done_s2 != done_s3;

  always_comb begin
    my_addr = SLAVE_ADDR_BASE;
    my_addr[SLAVE_ADDR_PIN_BIT] = adr5_s2;
  end

  always_comb begin
    unique case (sub_ptr)
      SUB_CTRL: rd_byte = ctrl_reg;
      SUB_POWER: rd_byte = pwr_reg;
      SUB_STATUS: rd_byte = {5'h00, auto_mode, busy, done_flag};
      SUB_PHASE: rd_byte = {2'h0, phase_reg};
      SUB_LENGTH: rd_byte = {5'h00, len_reg};
      SUB_ESTIMATE: rd_byte = {2'h0, coarse_estimate_output_pin};
      SUB_PHASE_USED: rd_byte = {2'h0, phase_offset_steps};
      SUB_RESULT: begin
        if (ctrl_reg[CTRL_SEL_LSB +: 3] < TALLY_BYTES) begin
          rd_byte = error_tally[8 * int'(ctrl_reg[CTRL_SEL_LSB +: 3]) +: 8];
        end else begin
          rd_byte = 8'h00;
        end
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // Serial slave sequencer.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      sub_ptr <= SUB_FIRST;
      rw_read <= 1'b0;
      sda_oe <= 1'b0;
      wr_strobe <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_strobe <= 1'b0;
      if (stop_seen) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_seen) begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: ;
          ST_ADDR, ST_SUB, ST_WR: begin
            if (scl_rise && bit_cnt != 4'h8) begin
              shift <= {shift[6:0], sda_s2};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (state == ST_ADDR) begin
                if (shift[7:1] == my_addr) begin
                  sda_oe <= 1'b1;
                  rw_read <= shift[0];
                  state <= ST_ADDR_ACK;
                end else begin
                  state <= ST_IDLE;
                end
              end else if (state == ST_SUB) begin
                if (sub_valid(shift)) begin
                  sub_ptr <= shift;
                  sda_oe <= 1'b1;
                  state <= ST_SUB_ACK;
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                wr_strobe <= 1'b1;
                wr_addr <= sub_ptr;
                wr_data <= shift;
                sub_ptr <= next_sub(sub_ptr);
                sda_oe <= 1'b1;
                state <= ST_WR_ACK;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              if (rw_read) begin
                tx <= rd_byte;
                sda_oe <= !rd_byte[7];
                state <= ST_RD;
              end else begin
                sda_oe <= 1'b0;
                state <= ST_SUB;
              end
            end
          end
          ST_SUB_ACK, ST_WR_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              state <= ST_WR;
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
                sub_ptr <= next_sub(sub_ptr);
                state <= ST_RD_ACK;
              end else begin
                bit_cnt <= bit_cnt + 4'h1;
                tx <= {tx[6:0], 1'b0};
                sda_oe <= !tx[6];
              end
            end
          end
          ST_RD_ACK: begin
            if (scl_rise && sda_s2) begin
              state <= ST_IDLE;
            end else if (scl_fall) begin
              tx <= rd_byte;
              sda_oe <= !rd_byte[7];
              state <= ST_RD;
            end
          end
          default: begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Writable registers and the start-bit falling transition.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RST;
      pwr_reg <= PWR_RST;
      phase_reg <= PHASE_RST;
      len_reg <= LEN_RST;
      host_start <= 1'b0;
    end else begin
      host_start <= 1'b0;
      if (wr_strobe) begin
        unique case (wr_addr)
          SUB_CTRL: begin
            ctrl_reg <= wr_data;
            host_start <= ctrl_reg[CTRL_START_BIT] && !wr_data[CTRL_START_BIT];
          end
          SUB_POWER: pwr_reg <= wr_data;
          SUB_PHASE: phase_reg <= clamp_phase(wr_data[5:0]);
          SUB_LENGTH: len_reg <= wr_data[2:0];
          default: ;
        endcase
      end
    end
  end

  // Host starts are ignored in autonomous mode and while a run is busy.
  assign launch = !busy && (auto_mode || host_start);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done_flag <= 1'b0;
      start_tgl <= 1'b0;
      cfg <= '0;
      error_tally <= '0;
      coarse_estimate_output_pin <= 6'h00;
    end else begin
      cfg.run_enable <= auto_mode || (pwr_reg[PWR_ON_BIT] && !pwr_reg[PWR_STBY_BIT]);
      if (done_edge) begin
        busy <= 1'b0;
        done_flag <= 1'b1;
        error_tally <= engine_tally;
        if (auto_mode) begin
          coarse_estimate_output_pin <= scbm_coarse_code(engine_tally);
        end
      end else if (launch) begin
        busy <= 1'b1;
        done_flag <= 1'b0;
        start_tgl <= !start_tgl;
        cfg.len_code <= auto_mode ? AUTO_LEN_CODE : len_reg;
      end
    end
  end

  // Power outputs; only an off/on change of meas_power_on (power bit or autonomous mode) requests relock.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meas_power_on <= 1'b0;
      meas_standby <= 1'b0;
      relock_request <= 1'b0;
      phase_offset_steps <= PHASE_RST;
      sda_out <= 1'b0;
    end else begin
      meas_power_on <= pwr_reg[PWR_ON_BIT] || auto_mode;
      meas_standby <= pwr_reg[PWR_ON_BIT] && pwr_reg[PWR_STBY_BIT] && !auto_mode;
      relock_request <= meas_power_on != (pwr_reg[PWR_ON_BIT] || auto_mode);
      phase_offset_steps <= auto_mode ? AUTO_PHASE_STEPS : phase_reg;
      sda_out <= 1'b0;
    end
  end

  scbm_engine #(
    .LEN_LOG2_BASE(LEN_LOG2_BASE)
  ) u_engine (
    .rec_clk(rec_clk),
    .rec_rst_n(rec_rst_n),
    .start_tgl(start_tgl),
    .cfg(cfg),
    .bit_error(bit_error),
    .done_tgl(engine_done_tgl),
    .tally(engine_tally)
  );

endmodule

//--- scbm_assertions.sv
// Concurrent checks on the ports of the two-wire control and measurement block.
// Assumes the serial master holds its clock low for several system clocks per bit.
`timescale 1ns/1ns
module scbm_assertions #(
  parameter int LEN_LOG2_BASE = 18
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rec_clk,
  input wire logic rec_rst_n,
  input wire logic scl_pin,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic address_bit5_pin,
  input wire logic coarse_output_select_pin,
  input wire logic bit_error,
  input wire logic meas_power_on,
  input wire logic meas_standby,
  input wire logic relock_request,
  input wire logic [5:0] phase_offset_steps,
  input wire logic [5:0] coarse_estimate_output_pin
);
  import scbm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_auto_held;
    !coarse_output_select_pin [*8];
  endsequence
  sequence s_power_moved;
    (meas_power_on != $past(meas_power_on)) ##0 1'b1;
  endsequence
  a_sda_out_low: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_pin)
    else $error("data line moved while serial clock high");
  a_standby_on: assert property (meas_standby |-> meas_power_on)
    else $error("standby without power");
  a_relock_change: assert property (s_power_moved |-> ##[0:1] relock_request)
    else $error("power change without relock");
  a_relock_once: assert property (relock_request |=> !relock_request)
    else $error("relock longer than one cycle");
  a_relock_cause: assert property (relock_request |-> $changed(meas_power_on) ||
      ($past(meas_power_on) != $past(meas_power_on, 2)))
    else $error("relock without power change");
  a_phase_range: assert property ($signed(phase_offset_steps) >= -6'sh1E &&
      $signed(phase_offset_steps) <= 6'sh1E)
    else $error("phase outside half interval");
  a_auto_phase: assert property (s_auto_held |-> phase_offset_steps == AUTO_PHASE_STEPS &&
      meas_power_on && !meas_standby)
    else $error("autonomous mode settings wrong");
endmodule
bind scbm_top scbm_assertions #(.LEN_LOG2_BASE(LEN_LOG2_BASE)) scbm_assertions_i (
  .clk, .rst_n, .rec_clk, .rec_rst_n, .scl_pin, .sda_in, .sda_out, .sda_oe,
  .address_bit5_pin, .coarse_output_select_pin, .bit_error, .meas_power_on,
  .meas_standby, .relock_request, .phase_offset_steps, .coarse_estimate_output_pin);

//--- scbm_bus_master.sv
// Two-wire bus master model: drives the serial clock and pulls the data wire.
// Assumes the bench resolves the data wire with a pull-up from all enables.
`timescale 1ns/1ns
module scbm_bus_master #(
  parameter int Q = 6
) (
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wait_q();
    repeat (Q) @(posedge clk);
  endtask
  // Data falls while the clock is high; one condition per clock high.
  task automatic start();
    sda_low <= 1'b0;
    wait_q();
    scl <= 1'b1;
    wait_q();
    sda_low <= 1'b1;
    wait_q();
    scl <= 1'b0;
    wait_q();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    wait_q();
    scl <= 1'b1;
    wait_q();
    sda_low <= 1'b0;
    wait_q();
  endtask
  // Up to nine bits, most significant first; the ninth is the acknowledge slot.
  task automatic frame(input logic [8:0] tx, output logic [8:0] rx, input int nb = 9);
    rx = 9'h1FF;
    for (int i = 8; i > 8 - nb; i--) begin
      sda_low <= !tx[i];
      wait_q();
      scl <= 1'b1;
      wait_q();
      rx[i] = sda_wire;
      scl <= 1'b0;
      wait_q();
    end
  endtask
endmodule

//--- tb_top.sv
// Self-checking bench for the two-wire control and measurement block.
// Assumes a shortened measurement length base and a pulled-up data wire.
`timescale 1ns/1ns
module tb_top;
  import scbm_pkg::*;
  localparam int BASE = 4;
  logic clk = 1'b0, rst_n = 1'b0, rec_clk = 1'b0, rec_rst_n = 1'b0;
  logic address_bit5_pin = 1'b0, coarse_output_select_pin = 1'b1;
  logic bit_error = 1'b0, err_mode = 1'b0;
  logic sda_out, sda_oe, meas_power_on, meas_standby, relock_request, scl, m_low;
  logic [5:0] phase_offset_steps, coarse_estimate_output_pin;
  logic [6:0] dev;
  wire sda = !(m_low || (sda_oe && !sda_out));
  int err_total = 0, comparisons = 0, relocks = 0;
  always #10 clk = ~clk;
  initial begin
    #7;
    forever #24 rec_clk = ~rec_clk;
  end
  always @(posedge rec_clk) bit_error <= err_mode;
  always @(posedge clk) if (relock_request === 1'b1) relocks <= relocks + 1;
  scbm_top #(.LEN_LOG2_BASE(BASE)) scbm_top_i (.clk, .rst_n, .rec_clk, .rec_rst_n,
    .scl_pin(scl), .sda_in(sda), .sda_out, .sda_oe, .address_bit5_pin,
    .coarse_output_select_pin, .bit_error, .meas_power_on, .meas_standby,
    .relock_request, .phase_offset_steps, .coarse_estimate_output_pin);
  scbm_bus_master scbm_bus_master_i (.clk, .sda_wire(sda), .scl, .sda_low(m_low));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic [8:0] rx;
    scbm_bus_master_i.frame({d, 1'b1}, rx);
    ack = !rx[0];
  endtask
  task automatic reg_wr(input logic [7:0] sub, input logic [15:0] d, input int n);
    logic a;
    int acks = 0;
    scbm_bus_master_i.start();
    put({dev, 1'b0}, a);
    acks += a;
    put(sub, a);
    acks += a;
    for (int i = 0; i < n; i++) begin
      put((n == 2 && i == 0) ? d[15:8] : d[7:0], a);
      acks += a;
    end
    scbm_bus_master_i.stop();
    check(8'(acks), 8'(n + 2));
  endtask
  task automatic reg_rd(input logic [7:0] sub, input int n, output logic [23:0] q);
    logic a0, a1, a2;
    logic [8:0] rx;
    q = '0;
    scbm_bus_master_i.start();
    put({dev, 1'b0}, a0);
    put(sub, a1);
    scbm_bus_master_i.start();
    put({dev, 1'b1}, a2);
    check({5'h00, a0, a1, a2}, 8'h07);
    for (int i = 1; i <= n; i++) begin
      scbm_bus_master_i.frame({8'hFF, i == n}, rx);
      q = {q[15:0], rx[8:1]};
    end
    scbm_bus_master_i.stop();
  endtask
  task automatic t_address();
    logic a, b;
    logic [6:0] m [3] = '{7'h01, 7'h20, 7'h40};
    for (int p = 0; p < 2; p++) begin
      address_bit5_pin <= p[0];
      dev = {1'b1, p[0], 5'h00};
      repeat (8) @(posedge clk);
      foreach (m[k]) begin
        scbm_bus_master_i.start();
        put({dev ^ m[k], 1'b0}, a);
        put(SUB_PHASE, b);
        scbm_bus_master_i.stop();
        check({6'h00, a, b}, 8'h00);
      end
      reg_wr(SUB_PHASE, 16'h0003, 1);
      check({2'h0, phase_offset_steps}, 8'h03);
    end
  endtask
  task automatic t_phase();
    logic [23:0] q;
    logic [7:0] w [4] = '{8'h1F, 8'h20, 8'h05, 8'h3A};
    logic [7:0] e [4] = '{8'h1E, 8'h22, 8'h05, 8'h3A};
    foreach (w[i]) begin
      reg_wr(SUB_PHASE, {8'h00, w[i]}, 1);
      check({2'h0, phase_offset_steps}, e[i]);
    end
    reg_wr(SUB_PHASE, 16'h0702, 2);
    reg_rd(SUB_PHASE, 2, q);
    check(q[15:8], 8'h07);
    check(q[7:0], 8'h02);
  endtask
  task automatic t_power();
    logic [7:0] p [4] = '{8'h20, 8'h30, 8'h20, 8'h00};
    int r [4] = '{1, 0, 0, 1};
    int b;
    foreach (p[i]) begin
      b = relocks;
      reg_wr(SUB_POWER, {8'h00, p[i]}, 1);
      check({6'h00, meas_power_on, meas_standby}, {6'h00, p[i][5], &p[i][5:4]});
      check(8'(relocks - b), 8'(r[i]));
    end
  endtask
  task automatic t_errors();
    logic a, b;
    logic [8:0] rx;
    logic [7:0] bad [2] = '{8'h19, 8'h22};
    foreach (bad[i]) begin
      scbm_bus_master_i.start();
      put({dev, 1'b0}, a);
      put(bad[i], a);
      put(SUB_PHASE, b);
      scbm_bus_master_i.stop();
      check({6'h00, a, b}, 8'h00);
    end
    for (int k = 0; k < 2; k++) begin
      scbm_bus_master_i.start();
      put({dev, 1'b0}, a);
      put(SUB_PHASE, a);
      scbm_bus_master_i.frame(9'h001, rx, 3);
      if (k == 0) begin
        reg_wr(SUB_PHASE, 16'h0009, 1);
      end else begin
        scbm_bus_master_i.stop();
      end
      check({2'h0, phase_offset_steps}, 8'h09);
    end
  endtask
  task automatic t_measure();
    logic [23:0] q;
    logic [39:0] exp = 40'h00_0000_0400;
    err_mode = 1'b1;
    reg_wr(SUB_POWER, 16'h0020, 1);
    reg_wr(SUB_LENGTH, 16'h0002, 1);
    for (int run = 0; run < 2; run++) begin
      reg_wr(SUB_CTRL, 16'h0009, 1);
      reg_wr(SUB_CTRL, 16'h0001, 1);
      reg_rd(SUB_STATUS, 1, q);
      check(q[7:0] & 8'h03, 8'h02);
      reg_rd(SUB_RESULT, 1, q);
      if (run == 1) check(q[7:0], 8'h04);
      for (int t = 0; t < 40 && q[0] !== 1'b1; t++) reg_rd(SUB_STATUS, 1, q);
      check(q[7:0] & 8'h03, 8'h01);
      reg_rd(SUB_RESULT, 3, q);
      check(q[23:16], exp[15:8]);
      check(q[7:0], exp[15:8]);
      for (int s = 0; s < 5; s++) begin
        reg_wr(SUB_CTRL, 16'(s), 1);
        reg_rd(SUB_RESULT, 1, q);
        check(q[7:0], exp[8*s +: 8]);
      end
      err_mode = 1'b0;
      exp = '0;
    end
  endtask
  task automatic t_auto();
    logic [23:0] q;
    err_mode = 1'b1;
    coarse_output_select_pin <= 1'b0;
    for (int t = 0; t < 3000 && coarse_estimate_output_pin !== 6'(BASE + 1); t++) begin
      @(posedge clk);
    end
    check({2'h0, coarse_estimate_output_pin}, 8'(BASE + 1));
    check({2'h0, phase_offset_steps}, 8'(HALF_UI_DEG / 5 / PHASE_STEP_DEG));
    reg_rd(SUB_ESTIMATE, 1, q);
    check(q[7:0], 8'(BASE + 1));
    reg_rd(SUB_STATUS, 1, q);
    check(q[7:0] & 8'h04, 8'h04);
    coarse_output_select_pin <= 1'b1;
    err_mode = 1'b0;
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rec_rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_address();
    t_phase();
    t_power();
    t_errors();
    t_measure();
    t_auto();
    summarize();
  end
  initial begin
    #1900000;
    err_total++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
